/* File: shared/cieb_defs.svh */
`ifndef CIEB_DEFS_SVH
`define CIEB_DEFS_SVH

// register offsets
`define CIEB_ENABLE_OFFS     12'h36c
`define CIEB_STATUS_OFFS     12'h368
`define CIEB_ADDR_W          12
`define CIEB_DATA_W          32

// enable and status bit positions
`define CIEB_BIT_FRAME_TIMER 29
`define CIEB_BIT_FRAME_TRIG  28
`define CIEB_BIT_ADC_B       25
`define CIEB_BIT_ADC_A       24
`define CIEB_BIT_DAC_B       17
`define CIEB_BIT_DAC_A       16
`define CIEB_BIT_IN_COUNT    12
`define CIEB_BIT_IN_DMA      8
`define CIEB_BIT_OUT_COUNT   4
`define CIEB_BIT_OUT_DMA     0

// termination cause field in the status register
`define CIEB_CAUSE_LSB       9
`define CIEB_CAUSE_MSB       10

// writable masks and reset values
`define CIEB_MASK_FULL       32'h3303_1111
`define CIEB_MASK_REDUCED    32'h3101_1111
`define CIEB_ENABLE_RESET    32'h0000_0000
`define CIEB_STATUS_RESET    32'h0000_0000

`endif

/* File: shared/cieb_pkg.sv */
package cieb_pkg;

  // register access request from the host side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cieb_reg_req_t;

  // event sources, pulses unless noted
  typedef struct packed {
    logic       frame_timer_expired;
    logic       frame_trigger_seen;
    logic       manual_mode;          // level
    logic       adc_a_converting;     // level
    logic       adc_b_converting;     // level
    logic       dac_a_settling;       // level
    logic       dac_b_settling;       // level
    logic       in_seq_count_done;
    logic       in_dma_buffer_end;
    logic [1:0] in_dma_end_cause;
    logic       out_seq_count_done;
    logic       out_dma_buffer_end;
  } cieb_events_t;

  // whole state of the top module
  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] status;
    logic [1:0]  cause;
    logic        irq;
    logic [31:0] rdata;
    logic        rvalid;
  } cieb_state_t;

endpackage : cieb_pkg

/* File: src/cieb_fall_det.sv */
module cieb_fall_det #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] level_i,
  output logic      [N-1:0] fall_o
);
  import cieb_pkg::*;

  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;

  // previous level of each line
  always_comb
  begin
    prev_d = level_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_q <= '0;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

  // one-cycle pulse when a line drops from one to zero
  for (genvar g = 0; g < N; g++)
  begin : g_fall
    assign fall_o[g] = prev_q[g] & ~level_i[g];
  end

endmodule : cieb_fall_det

/* File: src/cieb_top.sv */
`include "cieb_defs.svh"

module cieb_top #(
  parameter bit REDUCED_CHANNELS = 1'b0
) (
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_I,
  input  wire cieb_pkg::cieb_reg_req_t REG_REQ_I,
  input  wire cieb_pkg::cieb_events_t  EVENTS_I,
  output logic [31:0]                 REG_RDATA_O,
  output logic                        REG_RVALID_O,
  output logic                        IRQ_O
);
  import cieb_pkg::*;

  localparam logic [31:0] WR_MASK = REDUCED_CHANNELS ? `CIEB_MASK_REDUCED : `CIEB_MASK_FULL;

  cieb_state_t s_q;
  cieb_state_t s_d;
  logic [3:0]  levels;
  logic [3:0]  falls;
  logic [31:0] ev_vec;
  logic [31:0] set_vec;
  logic        wr_en;
  logic        wr_st;

  // converter flags: 0 adc a, 1 adc b, 2 dac a, 3 dac b
  assign levels = {EVENTS_I.dac_b_settling, EVENTS_I.dac_a_settling,
                   EVENTS_I.adc_b_converting, EVENTS_I.adc_a_converting};

  cieb_fall_det #(
    .N (4)
  ) u_fall (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .level_i (levels),
    .fall_o  (falls)
  );

  assign wr_en = REG_REQ_I.wr && (REG_REQ_I.addr == `CIEB_ENABLE_OFFS);
  assign wr_st = REG_REQ_I.wr && (REG_REQ_I.addr == `CIEB_STATUS_OFFS);

  // event vector laid out on the enable bit positions
  always_comb
  begin
    ev_vec = '0;
    ev_vec[`CIEB_BIT_FRAME_TIMER] = EVENTS_I.frame_timer_expired;
    ev_vec[`CIEB_BIT_FRAME_TRIG]  = EVENTS_I.frame_trigger_seen;
    ev_vec[`CIEB_BIT_ADC_A]       = EVENTS_I.manual_mode & falls[0];
    ev_vec[`CIEB_BIT_ADC_B]       = EVENTS_I.manual_mode & falls[1];
    ev_vec[`CIEB_BIT_DAC_A]       = EVENTS_I.manual_mode & falls[2];
    ev_vec[`CIEB_BIT_DAC_B]       = EVENTS_I.manual_mode & falls[3];
    ev_vec[`CIEB_BIT_IN_COUNT]    = EVENTS_I.in_seq_count_done;
    ev_vec[`CIEB_BIT_IN_DMA]      = EVENTS_I.in_dma_buffer_end;
    ev_vec[`CIEB_BIT_OUT_COUNT]   = EVENTS_I.out_seq_count_done;
    ev_vec[`CIEB_BIT_OUT_DMA]     = EVENTS_I.out_dma_buffer_end;
  end

  // only the enable already stored may gate an event
  assign set_vec = ev_vec & s_q.enable & WR_MASK;

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    if (wr_en)
    begin
      s_d.enable = REG_REQ_I.wdata & WR_MASK;
    end
    // disabling or writing one clears a status bit, a new event wins over both
    s_d.status = s_q.status & s_d.enable;
    if (wr_st)
    begin
      s_d.status = s_d.status & ~REG_REQ_I.wdata;
    end
    s_d.status = s_d.status | set_vec;
    if (set_vec[`CIEB_BIT_IN_DMA])
    begin
      s_d.cause = EVENTS_I.in_dma_end_cause;
    end
    s_d.irq = |s_d.status;
    // register reads answer one cycle later, unmapped reads give zero
    if (REG_REQ_I.rd)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      if (REG_REQ_I.addr == `CIEB_ENABLE_OFFS)
      begin
        s_d.rdata = s_q.enable;
      end
      else if (REG_REQ_I.addr == `CIEB_STATUS_OFFS)
      begin
        s_d.rdata = s_q.status;
        s_d.rdata[`CIEB_CAUSE_MSB:`CIEB_CAUSE_LSB] = s_q.cause;
      end
    end
  end

  // state register
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_q.enable <= `CIEB_ENABLE_RESET;
      s_q.status <= `CIEB_STATUS_RESET;
      s_q.cause  <= 2'h0;
      s_q.irq    <= 1'b0;
      s_q.rdata  <= 32'h0000_0000;
      s_q.rvalid <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA_O  = s_q.rdata;
  assign REG_RVALID_O = s_q.rvalid;
  assign IRQ_O        = s_q.irq;

  // checks
  chk_frame_timer_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_q.enable[`CIEB_BIT_FRAME_TIMER] && EVENTS_I.frame_timer_expired
    |=> s_q.status[`CIEB_BIT_FRAME_TIMER] && IRQ_O)
    else $error("frame timer event lost");

  chk_frame_trig_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_q.enable[`CIEB_BIT_FRAME_TRIG] && EVENTS_I.frame_trigger_seen
    |=> s_q.status[`CIEB_BIT_FRAME_TRIG])
    else $error("frame trigger event lost");

  chk_adc_a_manual: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(s_q.status[`CIEB_BIT_ADC_A])
    |-> $past(EVENTS_I.manual_mode && s_q.enable[`CIEB_BIT_ADC_A])
        && $past(EVENTS_I.adc_a_converting, 2) && !$past(EVENTS_I.adc_a_converting))
    else $error("adc a done set without enabled manual falling edge");

  chk_dac_a_settle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_q.enable[`CIEB_BIT_DAC_A] && EVENTS_I.manual_mode && falls[2]
    |=> s_q.status[`CIEB_BIT_DAC_A])
    else $error("dac a settled event lost");

  chk_reduced_inert: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    REDUCED_CHANNELS |-> !s_q.enable[`CIEB_BIT_ADC_B] && !s_q.enable[`CIEB_BIT_DAC_B]
                         && !s_q.status[`CIEB_BIT_ADC_B] && !s_q.status[`CIEB_BIT_DAC_B])
    else $error("reserved channel b bit active on reduced build");

  chk_in_count_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.enable[`CIEB_BIT_IN_COUNT] && EVENTS_I.in_seq_count_done |=> s_q.status[`CIEB_BIT_IN_COUNT])
    and ($rose(s_q.status[`CIEB_BIT_IN_COUNT]) |-> $past(EVENTS_I.in_seq_count_done)))
    else $error("input count status does not follow its event");

  chk_out_count_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.enable[`CIEB_BIT_OUT_COUNT] && EVENTS_I.out_seq_count_done |=> s_q.status[`CIEB_BIT_OUT_COUNT])
    and ($rose(s_q.status[`CIEB_BIT_OUT_COUNT]) |-> $past(EVENTS_I.out_seq_count_done)))
    else $error("output count status does not follow its event");

  chk_out_dma_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.enable[`CIEB_BIT_OUT_DMA] && EVENTS_I.out_dma_buffer_end |=> s_q.status[`CIEB_BIT_OUT_DMA])
    and ($rose(s_q.status[`CIEB_BIT_OUT_DMA]) |-> $past(EVENTS_I.out_dma_buffer_end)))
    else $error("output dma end status does not follow its event");

  chk_dma_cause: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_q.enable[`CIEB_BIT_IN_DMA] && EVENTS_I.in_dma_buffer_end
    |=> s_q.status[`CIEB_BIT_IN_DMA] && (s_q.cause == $past(EVENTS_I.in_dma_end_cause)))
    else $error("input dma end cause not recorded");

  chk_enable_write: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en |=> s_q.enable == ($past(REG_REQ_I.wdata) & WR_MASK))
    else $error("enable register write not stored");

  chk_prior_enable: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 ((s_q.status & ~$past(s_q.status)) & ~$past(s_q.enable)) == 32'h0000_0000)
    else $error("status set while enable was clear");

  chk_disable_clears: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en && (set_vec == 32'h0000_0000)
    |=> (s_q.status & ~s_q.enable) == 32'h0000_0000)
    else $error("disabled source kept its status bit");

  chk_irq_level: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 IRQ_O == (s_q.status != 32'h0000_0000))
    else $error("interrupt output disagrees with status");

  chk_reserved_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    REG_REQ_I.rd && (REG_REQ_I.addr == `CIEB_ENABLE_OFFS)
    |=> REG_RVALID_O && ((REG_RDATA_O & ~WR_MASK) == 32'h0000_0000))
    else $error("reserved enable bits read nonzero");

  chk_adc_b_done: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !REDUCED_CHANNELS && s_q.enable[`CIEB_BIT_ADC_B] && EVENTS_I.manual_mode && falls[1]
    |=> s_q.status[`CIEB_BIT_ADC_B])
    else $error("adc b done event lost");

  chk_dac_b_settle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !REDUCED_CHANNELS && s_q.enable[`CIEB_BIT_DAC_B] && EVENTS_I.manual_mode && falls[3]
    |=> s_q.status[`CIEB_BIT_DAC_B])
    else $error("dac b settled event lost");

  chk_cause_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !set_vec[`CIEB_BIT_IN_DMA] |=> $stable(s_q.cause))
    else $error("termination cause changed without a buffer end");

  chk_read_answer: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 REG_RVALID_O == $past(REG_REQ_I.rd))
    else $error("read answer strobe out of step with the request");

endmodule : cieb_top

/* File: dv/cieb_event_src.sv */
module cieb_event_src (
  input  wire logic             clk_i,
  output cieb_pkg::cieb_events_t ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cieb_pkg::*;
  logic m;
  // idle sources: manual mode on, buffer end cause fixed at 2
  initial
  begin
    ev_o = '0;
    ev_o.manual_mode = 1'b1;
    ev_o.in_dma_end_cause = 2'h2;
  end
  // one-cycle event pulse, or a busy flag that is high for a cycle and then falls
  task automatic fire(input int i);
    @(posedge clk_i);
    #1;
    case (i)
      0: ev_o.frame_timer_expired = 1'b1;
      1: ev_o.frame_trigger_seen = 1'b1;
      2: ev_o.adc_a_converting = 1'b1;
      3: ev_o.adc_b_converting = 1'b1;
      4: ev_o.dac_a_settling = 1'b1;
      5: ev_o.dac_b_settling = 1'b1;
      6: ev_o.in_seq_count_done = 1'b1;
      7: ev_o.in_dma_buffer_end = 1'b1;
      8: ev_o.out_seq_count_done = 1'b1;
      default: ev_o.out_dma_buffer_end = 1'b1;
    endcase
    @(posedge clk_i);
    #1;
    m = ev_o.manual_mode;
    ev_o = '0;
    ev_o.manual_mode = m;
    ev_o.in_dma_end_cause = 2'h2;
    @(posedge clk_i);
  endtask : fire
endmodule : cieb_event_src

/* File: dv/cieb_top_test.sv */
`include "cieb_defs.svh"
module cieb_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cieb_pkg::*;
  localparam logic [31:0] NC = 32'hffff_f9ff; // hides the cause field
  localparam int SB [10] = '{29, 28, 24, 25, 16, 17, 12, 8, 4, 0};
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  cieb_reg_req_t req;
  cieb_events_t  ev;
  logic [31:0]   rdata;
  logic          rvalid;
  logic          irq;
  logic [31:0]   rdata_r;
  logic          rvalid_r;
  logic          irq_r;
  int            mismatches = 0;
  int            total_checks = 0;
  logic [31:0]   e;
  // 125 MHz clock
  always #4 clk = ~clk;
  cieb_top u_cieb_top (.CLOCK_I(clk), .RST_I(rst), .REG_REQ_I(req), .EVENTS_I(ev),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .IRQ_O(irq));
  // reduced-channel build fed with the same stimulus
  cieb_top #(.REDUCED_CHANNELS(1'b1)) u_cieb_top_reduced (.CLOCK_I(clk), .RST_I(rst), .REG_REQ_I(req),
    .EVENTS_I(ev), .REG_RDATA_O(rdata_r), .REG_RVALID_O(rvalid_r), .IRQ_O(irq_r));
  cieb_event_src u_cieb_event_src (.clk_i(clk), .ev_o(ev));
  // comparisons
  task automatic check_word(input string w, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask : check_word
  task automatic check_bit(input string w, input logic x, input logic g);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("BAD %s expected %b seen %b", w, x, g);
    end
  endtask : check_bit
  // register accesses, one strobe cycle each
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req.wr = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    check_bit("rvalid", 1'b1, rvalid);
    check_word("rdata", x, rdata & m);
  endtask : reg_read
  // one source: refused while disabled, then set, then cleared by write-one
  task automatic fire_case(input int i);
    e = (32'h1 << SB[i]) | ((i == 7) ? 32'h0000_0400 : 32'h0);
    reg_write(`CIEB_ENABLE_OFFS, 32'h0);
    u_cieb_event_src.fire(i);
    reg_read(`CIEB_STATUS_OFFS, 32'h0, NC);
    reg_write(`CIEB_ENABLE_OFFS, 32'h1 << SB[i]);
    u_cieb_event_src.fire(i);
    reg_read(`CIEB_STATUS_OFFS, e, (i == 7) ? '1 : NC);
    check_bit("irq set", 1'b1, irq);
    check_bit("irq reduced", !(i == 3 || i == 5), irq_r);
    reg_write(`CIEB_STATUS_OFFS, 32'h1 << SB[i]);
    reg_read(`CIEB_STATUS_OFFS, 32'h0, NC);
    check_bit("irq clear", 1'b0, irq);
    check_bit("irq reduced clear", 1'b0, irq_r);
  endtask : fire_case
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // main sequence
  initial
  begin
    req = '0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    reg_read(`CIEB_ENABLE_OFFS, 32'h0);
    check_bit("irq reset", 1'b0, irq);
    reg_write(`CIEB_ENABLE_OFFS, 32'hffff_ffff);
    reg_read(`CIEB_ENABLE_OFFS, 32'h3303_1111);
    check_bit("rvalid reduced", 1'b1, rvalid_r);
    check_word("enable reduced", `CIEB_MASK_REDUCED, rdata_r);
    reg_read(12'h000, 32'h0);
    for (int i = 0; i < 10; i++)
      fire_case(i);
    fork
      reg_write(`CIEB_ENABLE_OFFS, 32'h2000_0000);
      u_cieb_event_src.fire(0);
    join
    reg_read(`CIEB_STATUS_OFFS, 32'h0, NC);
    u_cieb_event_src.ev_o.manual_mode = 1'b0;
    reg_write(`CIEB_ENABLE_OFFS, 32'h0100_0000);
    u_cieb_event_src.fire(2);
    reg_read(`CIEB_STATUS_OFFS, 32'h0, NC);
    u_cieb_event_src.ev_o.manual_mode = 1'b1;
    reg_write(`CIEB_ENABLE_OFFS, 32'h1000_0000);
    u_cieb_event_src.fire(1);
    reg_read(`CIEB_STATUS_OFFS, 32'h1000_0000, NC);
    reg_write(`CIEB_ENABLE_OFFS, 32'h0);
    reg_read(`CIEB_STATUS_OFFS, 32'h0, NC);
    check_bit("irq off", 1'b0, irq);
    complete_run();
  end
  // watchdog
  initial
  begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule : cieb_top_test
